// file: core/scs_defines.vh
// constants of the shared register bank with lane select
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH

// bus address base, strap added in low bits
`define SCS_BASE_ADDR 7'h18
// id register content; value is arbitrary
`define SCS_ID_VALUE 8'h5a

`define SCS_OFS_STRAP 8'h00
`define SCS_OFS_ID 8'h01
`define SCS_OFS_SPARE_A 8'h02
`define SCS_OFS_SPARE_B 8'h03
`define SCS_OFS_CTRL 8'h04
`define SCS_OFS_STAT 8'h05
`define SCS_OFS_SPARE_C 8'h06
`define SCS_OFS_SPARE_D 8'h07
`define SCS_OFS_SEL 8'hff
`define SCS_OFS_LANE_INT 8'h01

`define SCS_RST_SPARE_A 8'h00
`define SCS_RST_SPARE_B 8'h00
`define SCS_RST_CTRL 8'h01
`define SCS_RST_STAT_RW 3'h0
`define SCS_RST_PROM_DONE 1'b1
`define SCS_RST_SPARE_C 8'h00
`define SCS_RST_SPARE_D 8'h05
`define SCS_RST_SEL 4'h0
`define SCS_RD_INVALID 8'h00

`define SCS_CTRL_SHRST 6
`define SCS_CTRL_MMRST 5
`define SCS_CTRL_FORCE 4
`define SCS_STAT_DIS 7
`define SCS_STAT_DONE 4
`define SCS_SEL_BCAST 3
`define SCS_SEL_EN 2
`define SCS_LANE_LOSS_BIT 4

`endif

// file: core/scs_sync2.v
// two-flop synchroniser for asynchronous inputs
module scs_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule // scs_sync2

// file: core/scs_lane_flag.v
// lock-loss sticky flag of one lane
module scs_lane_flag (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // lock level, already synchronised
  input wire lock,
  // read of the lane interrupt register
  input wire clr,
  // sticky flag
  output wire flag
);
  reg acq_reg;
  reg lock_d_reg;
  reg flag_reg;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acq_reg <= 1'b0;
      lock_d_reg <= 1'b0;
      flag_reg <= 1'b0;
    end
    else
    begin
      lock_d_reg <= lock;
      if (lock)
        acq_reg <= 1'b1;
      if (acq_reg && lock_d_reg && !lock)
        flag_reg <= 1'b1;
      else if (clr)
        flag_reg <= 1'b0;
    end
  end

  assign flag = flag_reg;
endmodule // scs_lane_flag

// file: core/scs_shared_regs.v
// shared register bank with lane select, reached over the management bus
`include "scs_defines.vh"

module scs_shared_regs (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // management bus pins, open drain data
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // address strap
  input wire [3:0] addr_strap,
  // lane side
  input wire [3:0] lane_lock,
  input wire [31:0] lane_rdata,
  output wire [3:0] lane_wr_en,
  output wire [7:0] lane_addr,
  output wire [7:0] lane_wdata,
  // configuration loader
  input wire prom_load_done,
  output wire force_prom_load,
  output wire prom_cfg_disable,
  output wire master_mode_reset,
  // status
  output wire [3:0] lane_irq_flags
);
  localparam ST_IDLE = 3'd0;
  localparam ST_RX = 3'd1;
  localparam ST_RXEND = 3'd2;
  localparam ST_ACK = 3'd3;
  localparam ST_TX = 3'd4;
  localparam ST_TXACK = 3'd5;

  localparam PH_ADDR = 2'd0;
  localparam PH_PTR = 2'd1;
  localparam PH_DATA = 2'd2;

  wire [9:0] sync_q;
  wire scl_s;
  wire sda_s;
  wire [3:0] lock_s;
  wire [3:0] strap_s;
  wire [3:0] flag_w;

  reg scl_d_reg;
  reg sda_d_reg;
  reg [1:0] strap_cnt_reg;
  reg [3:0] strap_reg;

  reg [2:0] st_reg;
  reg [1:0] phase_reg;
  reg [7:0] sh_reg;
  reg [2:0] bcnt_reg;
  reg rw_reg;
  reg mack_reg;
  reg [7:0] ptr_reg;
  reg sda_oe_reg;
  reg sda_out_reg;
  reg wr_pulse_reg;
  reg [7:0] wr_data_reg;
  reg [3:0] clr_reg;

  reg [7:0] spare_a_reg;
  reg [7:0] spare_b_reg;
  reg [7:0] ctrl_reg;
  reg [2:0] stat_rw_reg;
  reg prom_done_reg;
  reg [7:0] spare_c_reg;
  reg [7:0] spare_d_reg;
  reg [3:0] sel_reg;
  reg [3:0] lane_wr_reg;
  reg [7:0] lane_wdata_reg;

  reg [7:0] rd_mux;
  reg [7:0] lane_byte;
  reg [3:0] clr_next;

  wire start_w;
  wire stop_w;
  wire rise_w;
  wire fall_w;
  wire [6:0] dev_addr;
  wire lane_on;

  // pins cross into the clock domain before any use
  scs_sync2 #(
    .W(10)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({scl_in, sda_in, lane_lock, addr_strap}),
    .q(sync_q)
  );

  assign scl_s = sync_q[9];
  assign sda_s = sync_q[8];
  assign lock_s = sync_q[7:4];
  assign strap_s = sync_q[3:0];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_lane
      scs_lane_flag u_flag (
        .clk(clk),
        .rst_n(rst_n),
        .lock(lock_s[gi]),
        .clr(clr_reg[gi]),
        .flag(flag_w[gi])
      );
    end
  endgenerate

  assign start_w = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_w = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign rise_w = scl_s & ~scl_d_reg;
  assign fall_w = ~scl_s & scl_d_reg;
  assign dev_addr = `SCS_BASE_ADDR + {3'b000, strap_reg};
  assign lane_on = sel_reg[`SCS_SEL_EN];

  // strap is taken once the synchroniser has filled after release
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      strap_cnt_reg <= 2'd0;
      strap_reg <= 4'h0;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      if (strap_cnt_reg != 2'd3)
      begin
        strap_cnt_reg <= strap_cnt_reg + 2'd1;
        strap_reg <= strap_s;
      end
    end
  end

  // read data; lane registers sit on a same-clock bus from the lanes
  always @*
  begin
    rd_mux = 8'h00;
    clr_next = 4'h0;
    // read lane from low select bits
    case (sel_reg[1:0])
      2'd0: lane_byte = lane_rdata[7:0];
      2'd1: lane_byte = lane_rdata[15:8];
      2'd2: lane_byte = lane_rdata[23:16];
      default: lane_byte = lane_rdata[31:24];
    endcase
    if (ptr_reg == `SCS_OFS_SEL)
    begin
      rd_mux = `SCS_RD_INVALID;
    end
    else if (lane_on)
    begin
      rd_mux = lane_byte;
      if (ptr_reg == `SCS_OFS_LANE_INT)
      begin
        // flag seen and cleared on read
        rd_mux[`SCS_LANE_LOSS_BIT] = flag_w[sel_reg[1:0]];
        clr_next[sel_reg[1:0]] = 1'b1;
      end
    end
    else
    begin
      case (ptr_reg)
        `SCS_OFS_STRAP: rd_mux = {strap_reg, 4'h0};
        `SCS_OFS_ID: rd_mux = `SCS_ID_VALUE;
        `SCS_OFS_SPARE_A: rd_mux = spare_a_reg;
        `SCS_OFS_SPARE_B: rd_mux = spare_b_reg;
        `SCS_OFS_CTRL: rd_mux = ctrl_reg;
        `SCS_OFS_STAT: rd_mux = {stat_rw_reg, prom_done_reg,
                                 flag_w[0], flag_w[1], flag_w[2], flag_w[3]};
        `SCS_OFS_SPARE_C: rd_mux = spare_c_reg;
        `SCS_OFS_SPARE_D: rd_mux = spare_d_reg;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // bus slave: bits sampled on clock rise, driven after clock fall
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= ST_IDLE;
      phase_reg <= PH_ADDR;
      sh_reg <= 8'h00;
      bcnt_reg <= 3'd0;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      ptr_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
      sda_out_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_data_reg <= 8'h00;
      clr_reg <= 4'h0;
    end
    else
    begin
      wr_pulse_reg <= 1'b0;
      clr_reg <= 4'h0;
      if (stop_w)
      begin
        st_reg <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end
      else if (start_w)
      begin
        // a repeated start restarts at the address byte
        st_reg <= ST_RX;
        phase_reg <= PH_ADDR;
        bcnt_reg <= 3'd0;
        sda_oe_reg <= 1'b0;
      end
      else
      begin
        case (st_reg)
          ST_RX:
          begin
            if (rise_w)
            begin
              sh_reg <= {sh_reg[6:0], sda_s};
              if (bcnt_reg == 3'd7)
                st_reg <= ST_RXEND;
              else
                bcnt_reg <= bcnt_reg + 3'd1;
            end
          end
          ST_RXEND:
          begin
            if (fall_w)
            begin
              case (phase_reg)
                PH_ADDR:
                begin
                  if (sh_reg[7:1] == dev_addr)
                  begin
                    rw_reg <= sh_reg[0];
                    phase_reg <= PH_PTR;
                    sda_oe_reg <= 1'b1;
                    st_reg <= ST_ACK;
                  end
                  else
                    st_reg <= ST_IDLE;
                end
                PH_PTR:
                begin
                  ptr_reg <= sh_reg;
                  phase_reg <= PH_DATA;
                  sda_oe_reg <= 1'b1;
                  st_reg <= ST_ACK;
                end
                default:
                begin
                  wr_pulse_reg <= 1'b1;
                  wr_data_reg <= sh_reg;
                  sda_oe_reg <= 1'b1;
                  st_reg <= ST_ACK;
                end
              endcase
            end
          end
          ST_ACK:
          begin
            if (fall_w)
            begin
              bcnt_reg <= 3'd0;
              if (rw_reg)
              begin
                sh_reg <= rd_mux;
                clr_reg <= clr_next;
                sda_oe_reg <= ~rd_mux[7];
                st_reg <= ST_TX;
              end
              else
              begin
                sda_oe_reg <= 1'b0;
                st_reg <= ST_RX;
              end
            end
          end
          ST_TX:
          begin
            if (fall_w)
            begin
              if (bcnt_reg == 3'd7)
              begin
                sda_oe_reg <= 1'b0;
                st_reg <= ST_TXACK;
              end
              else
              begin
                sh_reg <= {sh_reg[6:0], 1'b0};
                sda_oe_reg <= ~sh_reg[6];
                bcnt_reg <= bcnt_reg + 3'd1;
              end
            end
          end
          ST_TXACK:
          begin
            if (rise_w)
              mack_reg <= ~sda_s;
            if (fall_w)
            begin
              if (mack_reg)
              begin
                // master wants more: same register is sent again
                sh_reg <= rd_mux;
                clr_reg <= clr_next;
                sda_oe_reg <= ~rd_mux[7];
                bcnt_reg <= 3'd0;
                st_reg <= ST_TX;
              end
              else
                st_reg <= ST_IDLE;
            end
          end
          default:
          begin
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // register file and write routing
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spare_a_reg <= `SCS_RST_SPARE_A;
      spare_b_reg <= `SCS_RST_SPARE_B;
      ctrl_reg <= `SCS_RST_CTRL;
      stat_rw_reg <= `SCS_RST_STAT_RW;
      prom_done_reg <= `SCS_RST_PROM_DONE;
      spare_c_reg <= `SCS_RST_SPARE_C;
      spare_d_reg <= `SCS_RST_SPARE_D;
      sel_reg <= `SCS_RST_SEL;
      lane_wr_reg <= 4'h0;
      lane_wdata_reg <= 8'h00;
    end
    else
    begin
      prom_done_reg <= prom_load_done;
      lane_wr_reg <= 4'h0;
      ctrl_reg[`SCS_CTRL_MMRST] <= 1'b0;
      if (ctrl_reg[`SCS_CTRL_SHRST])
      begin
        spare_a_reg <= `SCS_RST_SPARE_A;
        spare_b_reg <= `SCS_RST_SPARE_B;
        ctrl_reg <= `SCS_RST_CTRL;
        stat_rw_reg <= `SCS_RST_STAT_RW;
        spare_c_reg <= `SCS_RST_SPARE_C;
        spare_d_reg <= `SCS_RST_SPARE_D;
      end
      else if (wr_pulse_reg)
      begin
        if (ptr_reg == `SCS_OFS_SEL)
        begin
          sel_reg <= wr_data_reg[3:0];
        end
        else if (lane_on)
        begin
          lane_wdata_reg <= wr_data_reg;
          if (sel_reg[`SCS_SEL_BCAST])
            lane_wr_reg <= 4'hf;
          else
            lane_wr_reg <= 4'h1 << sel_reg[1:0];
        end
        else
        begin
          case (ptr_reg)
            `SCS_OFS_SPARE_A: spare_a_reg <= wr_data_reg;
            `SCS_OFS_SPARE_B: spare_b_reg <= wr_data_reg;
            `SCS_OFS_CTRL: ctrl_reg <= wr_data_reg;
            `SCS_OFS_STAT: stat_rw_reg <= wr_data_reg[7:5];
            `SCS_OFS_SPARE_C: spare_c_reg <= wr_data_reg;
            `SCS_OFS_SPARE_D: spare_d_reg <= wr_data_reg;
            default: spare_a_reg <= spare_a_reg;
          endcase
        end
      end
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe = sda_oe_reg;
  assign lane_wr_en = lane_wr_reg;
  assign lane_addr = ptr_reg;
  assign lane_wdata = lane_wdata_reg;
  assign force_prom_load = ctrl_reg[`SCS_CTRL_FORCE];
  assign prom_cfg_disable = stat_rw_reg[`SCS_STAT_DIS - 5];
  assign master_mode_reset = ctrl_reg[`SCS_CTRL_MMRST];
  assign lane_irq_flags = flag_w;
endmodule // scs_shared_regs

// file: tb/scs_shared_regs_monitor.sv
// assertion checker for the shared register bank ports
module scs_shared_regs_monitor (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // bus clock pin
  input wire scl_in,
  // lane side
  input wire [3:0] lane_wr_en,
  input wire [7:0] lane_addr,
  input wire [3:0] lane_irq_flags,
  // loader controls
  input wire force_prom_load,
  input wire prom_cfg_disable,
  input wire master_mode_reset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_mmr_pulse;
    master_mode_reset |=> !master_mode_reset;
  endproperty
  a_mmr_pulse: assert property (p_mmr_pulse) else $error("mode reset too long");
  property p_mmr_lowscl;
    $rose(master_mode_reset) |-> !scl_in;
  endproperty
  a_mmr_lowscl: assert property (p_mmr_lowscl) else $error("mode reset off write");
  property p_wr_gap;
    (lane_wr_en != 4'h0) |=> (lane_wr_en == 4'h0) [*8];
  endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("lane write repeated");
  property p_wr_target;
    (lane_wr_en != 4'h0) |-> (lane_wr_en == 4'hf) || $onehot(lane_wr_en);
  endproperty
  a_wr_target: assert property (p_wr_target) else $error("bad lane write set");
  property p_wr_addr;
    (lane_wr_en != 4'h0) |-> (lane_addr != 8'hff) && !scl_in;
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("select write reached lane");
  property p_force_lowscl;
    $changed(force_prom_load) |-> !scl_in;
  endproperty
  a_force_lowscl: assert property (p_force_lowscl) else $error("force moved off write");
  property p_dis_lowscl;
    $changed(prom_cfg_disable) |-> !scl_in;
  endproperty
  a_dis_lowscl: assert property (p_dis_lowscl) else $error("disable moved off write");
  // flags only drop on a lane interrupt register read, which happens with the bus clock low
  property p_flag_clr;
    (|($past(lane_irq_flags) & ~lane_irq_flags)) |-> !scl_in;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag dropped off read");

  c_bcast: cover property (lane_wr_en == 4'hf);
  c_single: cover property ($onehot(lane_wr_en));
  c_flag: cover property (|lane_irq_flags);
endmodule // scs_shared_regs_monitor

bind scs_shared_regs scs_shared_regs_monitor i_scs_shared_regs_monitor (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .lane_wr_en(lane_wr_en),
  .lane_addr(lane_addr), .lane_irq_flags(lane_irq_flags),
  .force_prom_load(force_prom_load), .prom_cfg_disable(prom_cfg_disable),
  .master_mode_reset(master_mode_reset)
);

// file: tb/scs_host.sv
// bus host model driving the management pins of the register bank
module scs_host (
  // clock
  input wire logic clk,
  // device address
  input wire logic [6:0] dev_addr,
  // bus pins
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl_in,
  output wire logic sda_in,
  // read results
  output logic rd_valid,
  output logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_low = 1'b0;
  logic a = 1'b1;
  logic [7:0] r8 = 8'h00;
  initial
  begin
    scl_in = 1'b1;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  // pull-up: the line is high unless a party pulls it low
  assign sda_in = !host_low && !(sda_oe && !sda_out);
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // one clock pulse; phases far longer than the synchroniser delay
  task automatic phase(input logic lo1, input logic lo2, input logic sc);
    tick(4);
    host_low <= lo1;
    tick(8);
    scl_in <= 1'b1;
    tick(5);
    a = sda_in;
    host_low <= lo2;
    tick(5);
    scl_in <= sc;
  endtask
  task automatic byte_io(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      phase(!b[i], !b[i], 1'b0);
      r8[i] = a;
    end
    phase(1'b0, 1'b0, 1'b0);
  endtask
  task automatic head(input logic [7:0] p);
    phase(1'b0, 1'b1, 1'b0);
    byte_io({dev_addr, 1'b0});
    byte_io(p);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    head(p);
    byte_io(d);
    phase(1'b1, 1'b0, 1'b1);
  endtask
  task automatic rd(input logic [7:0] p);
    head(p);
    phase(1'b0, 1'b1, 1'b0);
    byte_io({dev_addr, 1'b1});
    byte_io(8'hff);
    phase(1'b1, 1'b0, 1'b1);
    rd_data <= r8;
    rd_valid <= 1'b1;
    tick(1);
    rd_valid <= 1'b0;
  endtask
endmodule // scs_host

// file: tb/scs_shared_regs_test.sv
// self-checking bench of the shared register bank
module scs_shared_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr_strap = 4'h0;
  logic [3:0] lane_lock = 4'h0;
  logic [31:0] lane_rdata = 32'h0;
  logic prom_load_done = 1'b1;
  logic [6:0] dev_addr = 7'h18;
  wire scl_in, sda_in, sda_out, sda_oe, rd_valid;
  wire force_prom_load, prom_cfg_disable, master_mode_reset;
  wire [3:0] lane_wr_en;
  wire [3:0] lane_irq_flags;
  wire [7:0] lane_addr;
  wire [7:0] lane_wdata;
  wire [7:0] rd_data;
  logic [20:0] q[$];
  logic [7:0] v;
  logic [7:0] s;
  int err_total = 0;
  int checked = 0;
  int mmr_seen = 0;
  int n;

  always #20 clk = ~clk;

  scs_shared_regs i_scs_shared_regs (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap(addr_strap), .lane_lock(lane_lock),
    .lane_rdata(lane_rdata), .lane_wr_en(lane_wr_en), .lane_addr(lane_addr),
    .lane_wdata(lane_wdata), .prom_load_done(prom_load_done),
    .force_prom_load(force_prom_load), .prom_cfg_disable(prom_cfg_disable),
    .master_mode_reset(master_mode_reset), .lane_irq_flags(lane_irq_flags)
  );
  scs_host i_scs_host (
    .clk(clk), .dev_addr(dev_addr), .sda_oe(sda_oe), .sda_out(sda_out),
    .scl_in(scl_in), .sda_in(sda_in), .rd_valid(rd_valid), .rd_data(rd_data)
  );

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdx(input logic [7:0] p, input logic [7:0] e);
    q.push_back({1'b1, 12'h000, e});
    i_scs_host.rd(p);
  endtask
  task automatic lw(input logic [7:0] p);
    q.push_back({1'b0, s[3] ? 4'hf : 4'h1 << s[1:0], p, v});
    i_scs_host.wr(p, v);
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d pending %0d", checked, err_total, q.size());
    if (err_total == 0 && checked > 0 && q.size() == 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // outputs are looked at on the falling edge, settled half a period after launch
  always @(negedge clk)
  begin
    if (rst_n && lane_wr_en !== 4'h0)
      chk({1'b0, lane_wr_en, lane_addr, lane_wdata}, q.size() ? q.pop_front() : '1);
    if (rd_valid === 1'b1)
      chk({1'b1, 12'h000, rd_data}, q.size() ? q.pop_front() : '1);
    if (master_mode_reset === 1'b1)
      mmr_seen++;
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    summarize();
  end

  initial
  begin
    v = 8'($urandom(32'h629c));
    s = 8'($urandom);
    addr_strap <= s[3:0];
    dev_addr <= 7'h18 + {3'h0, s[3:0]};
    lane_rdata <= $urandom;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    lane_lock <= 4'hf;
    repeat (5) @(posedge clk);
    rdx(8'h04, 8'h01);
    rdx(8'h05, 8'h10);
    rdx(8'h07, 8'h05);
    rdx(8'h03, 8'h00);
    v = 8'($urandom) | 8'h01;
    i_scs_host.wr(8'h06, v);
    rdx(8'h06, v);
    i_scs_host.wr(8'h05, 8'hff);
    rdx(8'h05, 8'hf0);
    chk(21'(prom_cfg_disable), 21'h1);
    i_scs_host.wr(8'h04, 8'h31);
    rdx(8'h04, 8'h11);
    chk(21'(force_prom_load), 21'h1);
    chk(21'(mmr_seen), 21'h1);
    i_scs_host.wr(8'h04, 8'h40);
    rdx(8'h04, 8'h01);
    rdx(8'h06, 8'h00);
    chk(21'({force_prom_load, prom_cfg_disable}), 21'h0);
    prom_load_done <= 1'b0;
    rdx(8'h05, 8'h00);
    prom_load_done <= 1'b1;
    rdx(8'hff, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      s = {4'h0, i[2], 1'b1, i[1:0]};
      v = 8'($urandom);
      i_scs_host.wr(8'hff, s);
      lw(8'h00);
      lw(8'h03);
      rdx(8'h00, lane_rdata[8 * s[1:0] +: 8]);
    end
    i_scs_host.wr(8'hff, 8'h0b);
    rdx(8'h00, {addr_strap, 4'h0});
    lane_lock <= 4'hb;
    n = 0;
    while (lane_irq_flags !== 4'h4 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk(21'(lane_irq_flags), 21'h4);
    if (n >= 20)
      summarize();
    rdx(8'h05, 8'h12);
    i_scs_host.wr(8'hff, 8'h06);
    rdx(8'h01, lane_rdata[23:16] | 8'h10);
    rdx(8'h01, lane_rdata[23:16] & 8'hef);
    chk(21'(lane_irq_flags), 21'h0);
    i_scs_host.wr(8'hff, 8'h00);
    rdx(8'h00, {addr_strap, 4'h0});
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule // scs_shared_regs_test
